// ==== design/fsi_consts.vh ====
// constants for the synthesizer two-wire write interface
// assumes inclusion by design files only; definitions only
`ifndef FSI_CONSTS_VH
`define FSI_CONSTS_VH
// ==================================================
// address byte
`define FSI_ADDR_FIXED     5'h18
`define FSI_DIR_WRITE      1'b0
`define FSI_ADDR_FIX_MSB   7
`define FSI_ADDR_FIX_LSB   3
`define FSI_ADDR_SEL_MSB   2
`define FSI_ADDR_SEL_LSB   1
`define FSI_ADDR_DIR_BIT   0
// ==================================================
// data byte fields
`define FSI_KIND_BIT       7
`define FSI_DIV_HIGH_MSB   6
`define FSI_DIV_HIGH_LSB   0
`define FSI_PORT_GRP_MSB   7
`define FSI_PORT_GRP_LSB   4
`define FSI_PORT_A_BIT     1
// ==================================================
// reference ratios
`define FSI_REF_640        11'h280
`define FSI_REF_1024       11'h400
`define FSI_REF_512        11'h200
// ==================================================
// control byte fields
`define FSI_CB_PUMP_CUR    6
`define FSI_CB_DIV_TEST    5
`define FSI_CB_PUMP_DIS    4
`define FSI_CB_PRESC       3
`define FSI_CB_REF_HIGH    2
`define FSI_CB_REF_LOW     1
`define FSI_CB_DRV_DIS     0
// ==================================================
// reset values and last bit index
`define FSI_CTRL_RESET     8'hC8
`define FSI_PORT_RESET     5'h00
`define FSI_DIV_RESET      15'h0000
`define FSI_BIT_LAST       3'h7
`endif

// ==== design/fsi_bus_sync.v ====
// two-flop synchroniser plus edge and bus condition detection
// assumes scl and sda come from pins asynchronous to clk_sys
`timescale 1ns/1ps
module fsi_bus_sync (
  clk_sys,
  rst,
  sclIn,
  sdaIn,
  sclLevel,
  sdaLevel,
  sclRise,
  sclFall,
  startSeen,
  stopSeen
);
  input  wire clk_sys;
  input  wire rst;
  input  wire sclIn;
  input  wire sdaIn;
  output wire sclLevel;
  output wire sdaLevel;
  output wire sclRise;
  output wire sclFall;
  output wire startSeen;
  output wire stopSeen;

  reg [1:0] sclMeta_q;
  reg [1:0] sdaMeta_q;
  reg       sclOld_q;
  reg       sdaOld_q;

  // ==================================================
  // synchronise
  always @(posedge clk_sys) begin
    if (rst) begin
      sclMeta_q <= 2'h3;
      sdaMeta_q <= 2'h3;
      sclOld_q  <= 1'b1;
      sdaOld_q  <= 1'b1;
    end else begin
      sclMeta_q <= {sclMeta_q[0], sclIn};
      sdaMeta_q <= {sdaMeta_q[0], sdaIn};
      sclOld_q  <= sclMeta_q[1];
      sdaOld_q  <= sdaMeta_q[1];
    end
  end

  assign sclLevel  = sclMeta_q[1];
  assign sdaLevel  = sdaMeta_q[1];
  assign sclRise   = sclMeta_q[1] & ~sclOld_q;
  assign sclFall   = ~sclMeta_q[1] & sclOld_q;
  // sda moves while scl stays high
  assign startSeen = sclMeta_q[1] & sclOld_q & sdaOld_q & ~sdaMeta_q[1];
  assign stopSeen  = sclMeta_q[1] & sclOld_q & ~sdaOld_q & sdaMeta_q[1];
endmodule // fsi_bus_sync

// ==== design/fsi_write_ctrl.v ====
// two-wire write interface of a tuner frequency synthesizer
// assumes an outside controller drives scl; sda is open drain, resolved outside
`timescale 1ns/1ps
`include "fsi_consts.vh"
module fsi_write_ctrl (
  clk_sys,
  rst,
  sclIn,
  sdaIn,
  sdaOut,
  sdaOe,
  addrSelectInput,
  threeWireMode,
  dividerRatioBits,
  pumpCurrentHigh,
  dividerTestEnable,
  pumpDisable,
  prescalerOn,
  refRatioLowBit,
  refRatioHighBit,
  refRatio,
  driveOutputDisable,
  switchOutputA,
  switchOutputsGroup,
  readRequest
);
  input  wire        clk_sys;
  input  wire        rst;
  input  wire        sclIn;
  input  wire        sdaIn;
  output reg         sdaOut;
  output reg         sdaOe;
  input  wire [1:0]  addrSelectInput;
  input  wire        threeWireMode;
  output reg  [14:0] dividerRatioBits;
  output reg         pumpCurrentHigh;
  output reg         dividerTestEnable;
  output reg         pumpDisable;
  output reg         prescalerOn;
  output reg         refRatioLowBit;
  output reg         refRatioHighBit;
  output reg  [10:0] refRatio;
  output reg         driveOutputDisable;
  output reg         switchOutputA;
  output reg  [3:0]  switchOutputsGroup;
  output reg         readRequest;

  // byte roles
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_FIRST = 3'h2;
  localparam [2:0] ST_DLOW  = 3'h3;
  localparam [2:0] ST_PORT  = 3'h4;
  localparam [2:0] ST_SKIP  = 3'h5;

  wire sclLevel;
  wire sdaLevel;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;

  reg [2:0] state_q;
  reg [2:0] bitCnt_q;
  reg [7:0] shift_q;
  reg [6:0] divHigh_q;
  reg       ackPend_q;
  reg       inAck_q;
  reg [1:0] selSync_q;
  reg [1:0] selLvl_q;
  reg       twSync_q;
  reg       twLvl_q;
  reg [7:0] ctrl_q;

  wire [7:0] byteNow = {shift_q[6:0], sdaLevel};

  // ==================================================
  // byte fields and latch strobes
  localparam GROUP_W = 4;

  wire       byteKind  = byteNow[`FSI_KIND_BIT];
  wire [4:0] addrFixed = byteNow[`FSI_ADDR_FIX_MSB:`FSI_ADDR_FIX_LSB];
  wire [1:0] addrSel   = byteNow[`FSI_ADDR_SEL_MSB:`FSI_ADDR_SEL_LSB];
  wire       addrDir   = byteNow[`FSI_ADDR_DIR_BIT];
  wire [6:0] divUpper  = byteNow[`FSI_DIV_HIGH_MSB:`FSI_DIV_HIGH_LSB];
  wire [3:0] portGroup = byteNow[`FSI_PORT_GRP_MSB:`FSI_PORT_GRP_LSB];
  wire       portA     = byteNow[`FSI_PORT_A_BIT];
  // last bit of a byte that the sequencer acts on
  wire       byteDone  = sclRise && !startSeen && !stopSeen && !inAck_q && !ackPend_q &&
                         (state_q != ST_IDLE) && (bitCnt_q == `FSI_BIT_LAST);
  wire       loadHigh  = byteDone && (state_q == ST_FIRST) && !byteKind;
  wire       loadCtrl  = byteDone && (state_q == ST_FIRST) && byteKind;
  wire       loadDiv   = byteDone && (state_q == ST_DLOW);
  wire       loadPort  = byteDone && (state_q == ST_PORT);

  fsi_bus_sync uSync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .sclLevel  (sclLevel),
    .sdaLevel  (sdaLevel),
    .sclRise   (sclRise),
    .sclFall   (sclFall),
    .startSeen (startSeen),
    .stopSeen  (stopSeen)
  );

  // ==================================================
  // pin straps through two flops
  always @(posedge clk_sys) begin
    if (rst) begin
      selSync_q <= 2'h0;
      selLvl_q  <= 2'h0;
      twSync_q  <= 1'b0;
      twLvl_q   <= 1'b0;
    end else begin
      selSync_q <= addrSelectInput;
      selLvl_q  <= selSync_q;
      twSync_q  <= threeWireMode;
      twLvl_q   <= twSync_q;
    end
  end

  wire addrMatch = (addrFixed == `FSI_ADDR_FIXED) &&
                   (addrSel == selLvl_q);

  // ==================================================
  // byte receiver and sequencer
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q          <= ST_IDLE;
      bitCnt_q         <= 3'h0;
      shift_q          <= 8'h00;
      ackPend_q        <= 1'b0;
      inAck_q          <= 1'b0;
      sdaOut           <= 1'b0;
      sdaOe            <= 1'b0;
      readRequest      <= 1'b0;
    end else if (startSeen || stopSeen) begin
      state_q     <= startSeen ? ST_ADDR : ST_IDLE;
      bitCnt_q    <= 3'h0;
      ackPend_q   <= 1'b0;
      inAck_q     <= 1'b0;
      sdaOe       <= 1'b0;
      readRequest <= 1'b0;
    end else if (inAck_q) begin
      // release sda after the acknowledge clock
      if (sclFall) begin
        inAck_q <= 1'b0;
        sdaOe   <= 1'b0;
      end
    end else if (ackPend_q) begin
      if (sclFall) begin
        ackPend_q <= 1'b0;
        inAck_q   <= 1'b1;
        sdaOe     <= 1'b1;
      end
    end else if (sclRise && state_q != ST_IDLE) begin
      shift_q  <= byteNow;
      bitCnt_q <= bitCnt_q + 3'h1;
      if (bitCnt_q == `FSI_BIT_LAST) begin
        case (state_q)
          ST_ADDR: begin
            if (addrMatch && addrDir == `FSI_DIR_WRITE) begin
              state_q   <= ST_FIRST;
              ackPend_q <= 1'b1;
            end else begin
              // read path lives elsewhere
              readRequest <= addrMatch;
              state_q     <= ST_SKIP;
            end
          end
          ST_FIRST: begin
            ackPend_q <= 1'b1;
            if (!byteKind) begin
              state_q <= ST_DLOW;
            end else begin
              state_q <= ST_PORT;
            end
          end
          ST_DLOW: begin
            ackPend_q <= 1'b1;
            state_q   <= ST_FIRST;
          end
          ST_PORT: begin
            ackPend_q <= 1'b1;
            state_q   <= ST_FIRST;
          end
          default: begin
            state_q <= ST_SKIP;
          end
        endcase
      end
    end
  end

  // ==================================================
  // divider, control and port latches
  always @(posedge clk_sys) begin
    if (rst) begin
      divHigh_q <= 7'h00;
    end else if (loadHigh) begin
      divHigh_q <= divUpper;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      dividerRatioBits <= `FSI_DIV_RESET;
    end else if (loadDiv) begin
      dividerRatioBits <= {divHigh_q, byteNow};
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= `FSI_CTRL_RESET;
    end else if (loadCtrl) begin
      ctrl_q <= byteNow;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      switchOutputA <= 1'b0;
    end else if (loadPort) begin
      switchOutputA <= portA;
    end
  end

  // one latch per grouped switch output
  genvar gi;
  generate
    for (gi = 0; gi < GROUP_W; gi = gi + 1) begin : gPort
      always @(posedge clk_sys) begin
        if (rst) begin
          switchOutputsGroup[gi] <= 1'b0;
        end else if (loadPort) begin
          switchOutputsGroup[gi] <= portGroup[gi];
        end
      end
    end
  endgenerate

  // ==================================================
  // control decode to registered outputs
  always @(posedge clk_sys) begin
    if (rst) begin
      pumpCurrentHigh    <= 1'b1;
      dividerTestEnable  <= 1'b0;
      pumpDisable        <= 1'b0;
      prescalerOn        <= 1'b1;
      refRatioLowBit     <= 1'b0;
      refRatioHighBit    <= 1'b0;
      driveOutputDisable <= 1'b0;
    end else begin
      pumpCurrentHigh    <= twLvl_q | ctrl_q[`FSI_CB_PUMP_CUR];
      dividerTestEnable  <= ctrl_q[`FSI_CB_DIV_TEST];
      pumpDisable        <= ctrl_q[`FSI_CB_PUMP_DIS];
      prescalerOn        <= ctrl_q[`FSI_CB_PRESC];
      refRatioLowBit     <= ctrl_q[`FSI_CB_REF_LOW];
      refRatioHighBit    <= ctrl_q[`FSI_CB_REF_HIGH];
      driveOutputDisable <= ctrl_q[`FSI_CB_DRV_DIS];
    end
  end

  // ==================================================
  // reference divider ratio
  always @(posedge clk_sys) begin
    if (rst) begin
      refRatio <= `FSI_REF_640;
    end else if (!ctrl_q[`FSI_CB_REF_LOW]) begin
      refRatio <= `FSI_REF_640;
    end else if (!ctrl_q[`FSI_CB_REF_HIGH]) begin
      refRatio <= `FSI_REF_1024;
    end else begin
      refRatio <= `FSI_REF_512;
    end
  end
endmodule // fsi_write_ctrl

// ==== testbench/fsi_write_ctrl_chk.sv ====
// assertions on the two-wire write interface outputs
// assumes binding to fsi_write_ctrl, one clock domain
`timescale 1ns/1ps
module fsi_write_ctrl_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        readRequest,
  input wire logic        threeWireMode,
  input wire logic        pumpCurrentHigh,
  input wire logic        refRatioHighBit,
  input wire logic        refRatioLowBit,
  input wire logic [10:0] refRatio,
  input wire logic [14:0] dividerRatioBits,
  input wire logic        switchOutputA,
  input wire logic [3:0]  switchOutputsGroup
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ====
  // acknowledge and latching
  a_ack_pulls_low: assert property (sdaOe |-> !sdaOut)
    else $error("ack not low");
  a_ack_scl_low: assert property (($rose(sdaOe) || $fell(sdaOe)) |-> !sclIn)
    else $error("ack edge with scl high");
  a_read_no_ack: assert property (readRequest |-> !sdaOe)
    else $error("ack in read");
  a_div_on_rise: assert property ($changed(dividerRatioBits) |-> sclIn)
    else $error("divider load off clock");
  a_port_on_rise: assert property ($changed({switchOutputA, switchOutputsGroup}) |-> sclIn)
    else $error("port load off clock");
  a_ref_decode: assert property ($stable({refRatioHighBit, refRatioLowBit}) |->
    refRatio == (!refRatioLowBit ? 11'h280 : refRatioHighBit ? 11'h200 : 11'h400))
    else $error("ref ratio wrong");
  a_three_wire_pump: assert property (threeWireMode [*6] |-> pumpCurrentHigh)
    else $error("pump not high");
  a_ports_reset: assert property (disable iff (1'b0) rst |=>
    !switchOutputA && switchOutputsGroup == 4'h0 && dividerRatioBits == 15'h0000)
    else $error("reset values wrong");
endmodule // fsi_write_ctrl_chk

bind fsi_write_ctrl fsi_write_ctrl_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .readRequest(readRequest), .threeWireMode(threeWireMode), .refRatio(refRatio),
  .pumpCurrentHigh(pumpCurrentHigh), .refRatioHighBit(refRatioHighBit),
  .refRatioLowBit(refRatioLowBit), .dividerRatioBits(dividerRatioBits),
  .switchOutputA(switchOutputA), .switchOutputsGroup(switchOutputsGroup)
);

// ==== testbench/fsi_bus_master.sv ====
// bus controller model: drives serial clock, pulls or releases data
// assumes sdaWire is the resolved data line with a pull-up
`timescale 1ns/1ps
module fsi_bus_master (
  input wire logic clk_sys,
  input wire logic sdaWire,
  output logic     sclOut,
  output logic     sdaDrv
);
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end
  // ====
  // bus phases of eight system clocks
  task automatic hold;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic startCond;
    sdaDrv <= 1'b1;
    hold;
    sclOut <= 1'b1;
    hold;
    sdaDrv <= 1'b0;
    hold;
    sclOut <= 1'b0;
    hold;
  endtask
  task automatic stopCond;
    sdaDrv <= 1'b0;
    hold;
    sclOut <= 1'b1;
    hold;
    sdaDrv <= 1'b1;
    hold;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaDrv <= b[i];
      hold;
      sclOut <= 1'b1;
      hold;
      sclOut <= 1'b0;
      hold;
    end
    sdaDrv <= 1'b1;
    hold;
    sclOut <= 1'b1;
    hold;
    ack = !sdaWire;
    sclOut <= 1'b0;
    hold;
  endtask
endmodule // fsi_bus_master

// ==== testbench/fsi_write_ctrl_test.sv ====
// self-checking bench of the two-wire write interface
// assumes the controller model and the bound checker
`timescale 1ns/1ps
module fsi_write_ctrl_test;
  logic        clk_sys, rst, threeWireMode;
  logic [1:0]  addrSelectInput, r;
  logic [14:0] d, dv, pv;
  logic [7:0]  c, p;
  int          fail_count = 0;
  int          cmp_count = 0;
  wire         sclIn, sdaDrv, sdaOut, sdaOe, readRequest, pumpCurrentHigh, pumpDisable;
  wire         dividerTestEnable, prescalerOn, refRatioLowBit, refRatioHighBit;
  wire         driveOutputDisable, switchOutputA;
  wire [14:0]  dividerRatioBits;
  wire [10:0]  refRatio;
  wire [3:0]   switchOutputsGroup;
  wire         sdaIn = sdaDrv & ~(sdaOe & ~sdaOut);
  wire [14:0]  ports = {10'h0, switchOutputsGroup, switchOutputA};
  fsi_bus_master m (.clk_sys(clk_sys), .sdaWire(sdaIn), .sclOut(sclIn), .sdaDrv(sdaDrv));
  fsi_write_ctrl dut (.clk_sys(clk_sys), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectInput(addrSelectInput),
    .threeWireMode(threeWireMode), .dividerRatioBits(dividerRatioBits),
    .pumpCurrentHigh(pumpCurrentHigh), .dividerTestEnable(dividerTestEnable),
    .pumpDisable(pumpDisable), .prescalerOn(prescalerOn), .refRatioLowBit(refRatioLowBit),
    .refRatioHighBit(refRatioHighBit), .refRatio(refRatio), .readRequest(readRequest),
    .driveOutputDisable(driveOutputDisable), .switchOutputA(switchOutputA),
    .switchOutputsGroup(switchOutputsGroup));
  // ====
  // tasks
  task automatic chk(input string n, input logic [14:0] e, input logic [14:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic e);
    logic a;
    m.sendByte(b, a);
    chk("ack", {14'h0, e}, {14'h0, a});
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    report_and_stop;
  end
  // ====
  // tests
  initial begin
    rst = 1'b1;
    threeWireMode = 1'b0;
    addrSelectInput = 2'h0;
    dv = 15'h0;
    pv = 15'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("div", 15'h0, dividerRatioBits);
    chk("port", 15'h0, ports);
    chk("ref", 15'h0280, {4'h0, refRatio});
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      addrSelectInput <= s[1:0];
      d = 15'h4A5C ^ {s[1:0], 13'h0};
      m.startCond;
      put({5'h18, s[1:0] + 2'h1, 1'b0}, 1'b0);
      m.startCond;
      put({5'h18, s[1:0], 1'b0}, 1'b1);
      put({1'b0, d[14:8]}, 1'b1);
      chk("early", dv, dividerRatioBits);
      put(d[7:0], 1'b1);
      chk("div", d, dividerRatioBits);
      dv = d;
      m.stopCond;
    end
    $display("address test done");
    m.startCond;
    put(8'hC6, 1'b1);
    for (int k = 3; k >= 0; k--) begin
      r = k[1:0];
      c = {1'b1, r[0], r[1], r[0], ~r[1], r, ~r[0]};
      p = {~r, r, 2'h0, r[0], 1'b0};
      put(c, 1'b1);
      chk("ctrl", {8'h0, c[6:0]}, {8'h0, pumpCurrentHigh, dividerTestEnable, pumpDisable,
        prescalerOn, refRatioHighBit, refRatioLowBit, driveOutputDisable});
      chk("ref", {4'h0, (!r[0] ? 11'h280 : r[1] ? 11'h200 : 11'h400)}, {4'h0, refRatio});
      chk("hold", pv, ports);
      put(p, 1'b1);
      pv = {10'h0, p[7:4], p[1]};
      chk("port", pv, ports);
    end
    put(8'h01, 1'b1);
    put(8'h00, 1'b1);
    chk("sweep", 15'h0100, dividerRatioBits);
    dv = 15'h0100;
    threeWireMode <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("pump", 15'h1, {14'h0, pumpCurrentHigh});
    threeWireMode <= 1'b0;
    m.stopCond;
    $display("control test done");
    m.startCond;
    put(8'hC6, 1'b1);
    put(8'h7F, 1'b1);
    m.startCond;
    put(8'hC6, 1'b1);
    put(8'h88, 1'b1);
    chk("lone", dv, dividerRatioBits);
    chk("presc", 15'h1, {14'h0, prescalerOn});
    m.startCond;
    put(8'hC7, 1'b0);
    chk("read", 15'h1, {14'h0, readRequest});
    m.stopCond;
    $display("restart test done");
    report_and_stop;
  end
endmodule // fsi_write_ctrl_test
